// ### logic/exception_syndrome_encoder.sv
// Exception syndrome encoder with software-visible 64-bit syndrome register
`timescale 1ns/1ps
module exception_syndrome_encoder #(
  parameter int REG_LSB = 5
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     exc_take_i,
  input  wire syndrome_pkg::exc_event_t exc_i,
  input  wire logic [3:0]               addr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic [31:0]                   rdata_o,
  output logic [63:0]                   exception_syndrome_o
);
  // The register subfield must fit inside the 25-bit syndrome
  if (REG_LSB < 0 || REG_LSB > syndrome_pkg::SYND_W - 5) begin : g_bad_reg_lsb
    $error("REG_LSB out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  syndrome_pkg::syndrome_t syn_ff;
  syndrome_pkg::syndrome_t nxt_syn;
  logic [3:0]              feat_ff;
  logic                    written_ff;
  logic [31:0]             rdata_ff;
  logic [5:0]              map_class;
  syndrome_pkg::src_t      took_src;

  syndrome_class_map syndrome_class_map_inst (
    .src_i    (exc_i.src),
    .lower_i  (exc_i.lower_level),
    .narrow_i (exc_i.from_narrow),
    .feat_i   (feat_ff),
    .class_o  (map_class)
  );

  // Narrow-state register 15 maps to 31 in the wide register view
  function automatic logic [4:0] wide_reg(input logic [3:0] r);
    return (r == syndrome_pkg::NARROW_REG_PC) ? syndrome_pkg::WIDE_REG_ZERO : {1'b0, r};
  endfunction

  // Length bit is forced to one wherever it carries no instruction size
  function automatic logic length_of(input syndrome_pkg::src_t s, input logic [5:0] cls,
                                     input logic wide, input logic sv);
    logic l;
    l = wide;
    case (s)
      syndrome_pkg::SRC_SYS_ERROR, syndrome_pkg::SRC_IABT, syndrome_pkg::SRC_PC_ALIGN,
      syndrome_pkg::SRC_SP_ALIGN, syndrome_pkg::SRC_ILLEGAL_STATE, syndrome_pkg::SRC_HW_COMPACT_BREAKPOINT_INSTR,
      syndrome_pkg::SRC_STEP, syndrome_pkg::SRC_WATCH: l = 1'b1;
      syndrome_pkg::SRC_DABT: l = sv ? wide : 1'b1;
      syndrome_pkg::SRC_BRK_INSTR: l = wide;
      default: l = wide;
    endcase
    if (cls == syndrome_pkg::EC_UNKNOWN) begin
      l = 1'b1;
    end
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_syn.exception_class_field   = map_class;
    nxt_syn.instruction_length_bit  = length_of(exc_i.src, map_class, exc_i.instr_wide,
                                                exc_i.syndrome_valid);
    nxt_syn.class_specific_syndrome = exc_i.detail;
    if (exc_i.reg_present && exc_i.from_narrow) begin
      nxt_syn.class_specific_syndrome[REG_LSB +: 5] = wide_reg(exc_i.narrow_reg);
      if (!exc_i.predictable) begin
        nxt_syn.class_specific_syndrome[REG_LSB +: 5] = syndrome_pkg::WIDE_REG_ZERO;
      end
    end
    if (map_class == syndrome_pkg::EC_UNKNOWN) begin
      nxt_syn.class_specific_syndrome = '0;
    end
  end

  // Fields carry no reset: their content is undefined until the first entry
  always_ff @(posedge clk_i) begin
    if (exc_take_i) begin
      syn_ff <= nxt_syn;
    end else if (wr_i && addr_i == syndrome_pkg::REG_SYND_LO) begin
      // Reserved class values are stored as written; software owns the outcome
      syn_ff <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      feat_ff <= syndrome_pkg::FEAT_RESET;
    end else if (wr_i && addr_i == syndrome_pkg::REG_FEATURES) begin
      feat_ff <= wdata_i[3:0];
    end
  end

  // Sticky "captured since read" flag; a new capture wins over the clearing read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      written_ff <= 1'b0;
    end else if (exc_take_i) begin
      written_ff <= 1'b1;
    end else if (rd_i && addr_i == syndrome_pkg::REG_STATUS) begin
      written_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        syndrome_pkg::REG_SYND_LO:  rdata_ff <= syn_ff;
        syndrome_pkg::REG_SYND_HI:  rdata_ff <= 32'h0000_0000;
        syndrome_pkg::REG_STATUS:   rdata_ff <= {31'h0, written_ff};
        syndrome_pkg::REG_FEATURES: rdata_ff <= {28'h000_0000, feat_ff};
        default:                    rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign rdata_o              = rdata_ff;
  assign exception_syndrome_o = {32'h0000_0000, syn_ff};

  // Source of the event taken this cycle, none when idle; keeps the checks short
  assign took_src = exc_take_i ? exc_i.src : syndrome_pkg::SRC_NONE;

  ////////////////////////////////////////////////////////////////////////////
  property p_iabt_class;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && exc_i.src == syndrome_pkg::SRC_IABT |=>
        syn_ff.exception_class_field == ($past(exc_i.lower_level) ? 6'h20 : 6'h21);
  endproperty
  a_iabt_class: assert property (p_iabt_class) else $error("instruction abort class wrong");

  property p_dabt_class;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && exc_i.src == syndrome_pkg::SRC_DABT |=>
        syn_ff.exception_class_field == ($past(exc_i.lower_level) ? 6'h24 : 6'h25);
  endproperty
  a_dabt_class: assert property (p_dabt_class) else $error("data abort class wrong");

  property p_sys_error;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && exc_i.src == syndrome_pkg::SRC_SYS_ERROR |=>
        syn_ff.exception_class_field == 6'h2f && syn_ff.instruction_length_bit;
  endproperty
  a_sys_error: assert property (p_sys_error) else $error("system error syndrome wrong");

  property p_unknown_zero;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i |=> syn_ff.exception_class_field != 6'h00
        || (syn_ff.instruction_length_bit && syn_ff.class_specific_syndrome == 25'h0);
  endproperty
  a_unknown_zero: assert property (p_unknown_zero) else $error("unknown class syndrome wrong");

  property p_brk_len;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && exc_i.src == syndrome_pkg::SRC_BRK_INSTR |=>
        syn_ff.instruction_length_bit == $past(exc_i.instr_wide)
        && syn_ff.exception_class_field == ($past(exc_i.from_narrow) ? 6'h38 : 6'h3c);
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("breakpoint instruction syndrome wrong");

  property p_debug_len;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && (exc_i.src == syndrome_pkg::SRC_STEP || exc_i.src == syndrome_pkg::SRC_WATCH)
        |=> syn_ff.instruction_length_bit;
  endproperty
  a_debug_len: assert property (p_debug_len) else $error("debug length bit not forced");

  property p_hi_zero;
    @(posedge clk_i) disable iff (rst_i) exception_syndrome_o[63:32] == 32'h0000_0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper syndrome bits not zero");

  property p_atomic;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i |=> syn_ff == $past(nxt_syn);
  endproperty
  a_atomic: assert property (p_atomic) else $error("syndrome not captured whole");

  property p_reg_pc;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && exc_i.reg_present && exc_i.from_narrow && exc_i.narrow_reg == 4'hf
        && map_class != 6'h00 |=> syn_ff.class_specific_syndrome[REG_LSB +: 5] == 5'h1f;
  endproperty
  a_reg_pc: assert property (p_reg_pc) else $error("register 15 not mapped to 31");

  property p_txn_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_TXN_BEGIN
        |=> syn_ff.exception_class_field == 6'h1b;
  endproperty
  a_txn_class: assert property (p_txn_class)
    else $error("transaction begin class wrong");

  property p_auth_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_PTR_AUTH
        |=> syn_ff.exception_class_field == ($past(feat_ff[0]) ? 6'h1c : 6'h00);
  endproperty
  a_auth_class: assert property (p_auth_class)
    else $error("authentication failure class wrong");

  property p_matrix_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_MATRIX
        |=> syn_ff.exception_class_field == 6'h1d;
  endproperty
  a_matrix_class: assert property (p_matrix_class)
    else $error("matrix trap class wrong");

  property p_granule_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_GRANULE
        |=> syn_ff.exception_class_field == ($past(feat_ff[1]) ? 6'h1e : 6'h00);
  endproperty
  a_granule_class: assert property (p_granule_class)
    else $error("granule fault class wrong");

  property p_pc_align;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_PC_ALIGN
        |=> syn_ff.exception_class_field == 6'h22 && syn_ff.instruction_length_bit;
  endproperty
  a_pc_align: assert property (p_pc_align)
    else $error("pc alignment syndrome wrong");

  property p_sp_align;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_SP_ALIGN
        |=> syn_ff.exception_class_field == 6'h26 && syn_ff.instruction_length_bit;
  endproperty
  a_sp_align: assert property (p_sp_align)
    else $error("sp alignment syndrome wrong");

  property p_fp_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_FP_TRAP
        |=> syn_ff.exception_class_field == (!$past(feat_ff[2]) ? 6'h00 :
                                             $past(exc_i.from_narrow) ? 6'h28 : 6'h2c);
  endproperty
  a_fp_class: assert property (p_fp_class)
    else $error("floating-point trap class wrong");

  property p_compact_breakpoint_instr_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_HW_COMPACT_BREAKPOINT_INSTR
        |=> syn_ff.exception_class_field == ($past(exc_i.lower_level) ? 6'h30 : 6'h31);
  endproperty
  a_compact_breakpoint_instr_class: assert property (p_compact_breakpoint_instr_class)
    else $error("hardware breakpoint class wrong");

  property p_step_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_STEP
        |=> syn_ff.exception_class_field == ($past(exc_i.lower_level) ? 6'h32 : 6'h33);
  endproperty
  a_step_class: assert property (p_step_class)
    else $error("single step class wrong");

  property p_watch_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_WATCH
        |=> syn_ff.exception_class_field == ($past(exc_i.lower_level) ? 6'h34 : 6'h35);
  endproperty
  a_watch_class: assert property (p_watch_class)
    else $error("watchpoint class wrong");

  property p_undef_class;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_UNDEF
        |=> syn_ff.exception_class_field == 6'h00;
  endproperty
  a_undef_class: assert property (p_undef_class)
    else $error("uncovered exception not unknown class");

  property p_len_plain;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_MATRIX
        |=> syn_ff.instruction_length_bit == $past(exc_i.instr_wide);
  endproperty
  a_len_plain: assert property (p_len_plain)
    else $error("length bit does not follow instruction size");

  property p_abort_len;
    @(posedge clk_i) disable iff (rst_i)
      took_src == syndrome_pkg::SRC_IABT || (took_src == syndrome_pkg::SRC_DABT && !exc_i.syndrome_valid)
        |=> syn_ff.instruction_length_bit;
  endproperty
  a_abort_len: assert property (p_abort_len)
    else $error("abort length bit not forced");

  property p_detail;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && !exc_i.reg_present && map_class != 6'h00
        |=> syn_ff.class_specific_syndrome == $past(exc_i.detail);
  endproperty
  a_detail: assert property (p_detail)
    else $error("syndrome detail not carried");

  property p_reg_unpred;
    @(posedge clk_i) disable iff (rst_i)
      exc_take_i && exc_i.reg_present && exc_i.from_narrow && !exc_i.predictable && map_class != 6'h00
        |=> syn_ff.class_specific_syndrome[REG_LSB +: 5] == 5'h1f;
  endproperty
  a_reg_unpred: assert property (p_reg_unpred)
    else $error("unpredictable register subfield wrong");

  property p_sw_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_i && addr_i == syndrome_pkg::REG_SYND_LO && !exc_take_i
        |=> syn_ff == $past(wdata_i);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software write not stored raw");

  c_iabt:  cover property (@(posedge clk_i) exc_take_i && exc_i.src == syndrome_pkg::SRC_IABT);
  c_brk:   cover property (@(posedge clk_i) exc_take_i && exc_i.src == syndrome_pkg::SRC_BRK_INSTR);
  c_undef: cover property (@(posedge clk_i) exc_take_i && map_class == syndrome_pkg::EC_UNKNOWN);
  c_read:  cover property (@(posedge clk_i) rd_i && addr_i == syndrome_pkg::REG_SYND_LO);
  c_feat:  cover property (@(posedge clk_i) exc_take_i && feat_ff != syndrome_pkg::FEAT_RESET);
endmodule

// ### shared/syndrome_pkg.sv
// Package: class codes, field layout and register map of the syndrome encoder
package syndrome_pkg;
  localparam logic [5:0] EC_UNKNOWN      = 6'h00;
  localparam logic [5:0] EC_TXN_BEGIN    = 6'h1b;
  localparam logic [5:0] EC_PTR_AUTH     = 6'h1c;
  localparam logic [5:0] EC_MATRIX       = 6'h1d;
  localparam logic [5:0] EC_GRANULE      = 6'h1e;
  localparam logic [5:0] EC_IABT_LOWER   = 6'h20;
  localparam logic [5:0] EC_IABT_SAME    = 6'h21;
  localparam logic [5:0] EC_PC_ALIGN     = 6'h22;
  localparam logic [5:0] EC_DABT_LOWER   = 6'h24;
  localparam logic [5:0] EC_DABT_SAME    = 6'h25;
  localparam logic [5:0] EC_SP_ALIGN     = 6'h26;
  localparam logic [5:0] EC_FP_NARROW    = 6'h28;
  localparam logic [5:0] EC_FP_WIDE      = 6'h2c;
  localparam logic [5:0] EC_SYS_ERROR    = 6'h2f;
  localparam logic [5:0] EC_COMPACT_BREAKPOINT_INSTR_LOWER   = 6'h30;
  localparam logic [5:0] EC_COMPACT_BREAKPOINT_INSTR_SAME    = 6'h31;
  localparam logic [5:0] EC_STEP_LOWER   = 6'h32;
  localparam logic [5:0] EC_STEP_SAME    = 6'h33;
  localparam logic [5:0] EC_WATCH_LOWER  = 6'h34;
  localparam logic [5:0] EC_WATCH_SAME   = 6'h35;
  localparam logic [5:0] EC_BRK_NARROW   = 6'h38;
  localparam logic [5:0] EC_BRK_WIDE     = 6'h3c;
  localparam logic [5:0] EC_SYNC_LAST    = 6'h2c;
  localparam int         CLASS_LSB       = 26;
  localparam int         CLASS_MSB       = 31;
  localparam int         LENGTH_BIT      = 25;
  localparam int         SYND_W          = 25;
  localparam logic [3:0] NARROW_REG_PC   = 4'hf;
  localparam logic [4:0] WIDE_REG_ZERO   = 5'h1f;
  localparam logic [3:0] REG_SYND_LO     = 4'h0;
  localparam logic [3:0] REG_SYND_HI     = 4'h4;
  localparam logic [3:0] REG_STATUS      = 4'h8;
  localparam logic [3:0] REG_FEATURES    = 4'hc;
  localparam logic [3:0] FEAT_RESET      = 4'hf;

  typedef enum logic [4:0] {
    SRC_NONE, SRC_TXN_BEGIN, SRC_PTR_AUTH, SRC_MATRIX, SRC_GRANULE, SRC_IABT, SRC_PC_ALIGN,
    SRC_DABT, SRC_SP_ALIGN, SRC_FP_TRAP, SRC_SYS_ERROR, SRC_HW_COMPACT_BREAKPOINT_INSTR, SRC_STEP, SRC_WATCH,
    SRC_BRK_INSTR, SRC_ILLEGAL_STATE, SRC_UNDEF
  } src_t;

  typedef struct packed {
    src_t        src;
    logic        lower_level;
    logic        from_narrow;
    logic        instr_wide;
    logic        syndrome_valid;
    logic [24:0] detail;
    logic        reg_present;
    logic [3:0]  narrow_reg;
    logic        predictable;
  } exc_event_t;

  typedef struct packed {
    logic [5:0]  exception_class_field;
    logic        instruction_length_bit;
    logic [24:0] class_specific_syndrome;
  } syndrome_t;
endpackage

// ### logic/syndrome_class_map.sv
// Combinational map from exception source to class code
`timescale 1ns/1ps
module syndrome_class_map (
  input  wire syndrome_pkg::src_t src_i,
  input  wire logic               lower_i,
  input  wire logic               narrow_i,
  input  wire logic [3:0]         feat_i,
  output logic [5:0]              class_o
);
  always_comb begin
    case (src_i)
      syndrome_pkg::SRC_TXN_BEGIN:  class_o = syndrome_pkg::EC_TXN_BEGIN;
      syndrome_pkg::SRC_PTR_AUTH:   class_o = feat_i[0] ? syndrome_pkg::EC_PTR_AUTH
                                                        : syndrome_pkg::EC_UNKNOWN;
      syndrome_pkg::SRC_MATRIX:     class_o = syndrome_pkg::EC_MATRIX;
      syndrome_pkg::SRC_GRANULE:    class_o = feat_i[1] ? syndrome_pkg::EC_GRANULE
                                                        : syndrome_pkg::EC_UNKNOWN;
      syndrome_pkg::SRC_IABT:       class_o = lower_i ? syndrome_pkg::EC_IABT_LOWER
                                                      : syndrome_pkg::EC_IABT_SAME;
      syndrome_pkg::SRC_DABT:       class_o = lower_i ? syndrome_pkg::EC_DABT_LOWER
                                                      : syndrome_pkg::EC_DABT_SAME;
      syndrome_pkg::SRC_PC_ALIGN:   class_o = syndrome_pkg::EC_PC_ALIGN;
      syndrome_pkg::SRC_SP_ALIGN:   class_o = syndrome_pkg::EC_SP_ALIGN;
      // Without trap support the codes are reserved, so fall back to unknown
      syndrome_pkg::SRC_FP_TRAP:    class_o = !feat_i[2] ? syndrome_pkg::EC_UNKNOWN :
                                              narrow_i ? syndrome_pkg::EC_FP_NARROW
                                                       : syndrome_pkg::EC_FP_WIDE;
      syndrome_pkg::SRC_SYS_ERROR:  class_o = syndrome_pkg::EC_SYS_ERROR;
      syndrome_pkg::SRC_HW_COMPACT_BREAKPOINT_INSTR:    class_o = lower_i ? syndrome_pkg::EC_COMPACT_BREAKPOINT_INSTR_LOWER
                                                      : syndrome_pkg::EC_COMPACT_BREAKPOINT_INSTR_SAME;
      syndrome_pkg::SRC_STEP:       class_o = lower_i ? syndrome_pkg::EC_STEP_LOWER
                                                      : syndrome_pkg::EC_STEP_SAME;
      syndrome_pkg::SRC_WATCH:      class_o = lower_i ? syndrome_pkg::EC_WATCH_LOWER
                                                      : syndrome_pkg::EC_WATCH_SAME;
      syndrome_pkg::SRC_BRK_INSTR:  class_o = narrow_i ? syndrome_pkg::EC_BRK_NARROW
                                                       : syndrome_pkg::EC_BRK_WIDE;
      default:                      class_o = syndrome_pkg::EC_UNKNOWN;
    endcase
  end
endmodule

// ### sim/exception_syndrome_encoder_tb.sv
// Self-checking bench for the exception syndrome encoder
`timescale 1ns/1ps
module exception_syndrome_encoder_tb;
  localparam int         REG_LSB   = 5;
  localparam logic [24:0] DETAIL   = 25'h0a5c3e1;

  logic                     clk_i;
  logic                     rst_i;
  logic                     exc_take_i;
  syndrome_pkg::exc_event_t exc_i;
  logic [3:0]               addr_i;
  logic [31:0]              wdata_i;
  logic                     wr_i;
  logic                     rd_i;
  logic [31:0]              rdata_o;
  logic [63:0]              exception_syndrome_o;
  int                       err_total;
  int                       total_checks;

  exception_syndrome_encoder #(.REG_LSB(REG_LSB)) exception_syndrome_encoder_inst (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .exc_take_i           (exc_take_i),
    .exc_i                (exc_i),
    .addr_i               (addr_i),
    .wdata_i              (wdata_i),
    .wr_i                 (wr_i),
    .rd_i                 (rd_i),
    .rdata_o              (rdata_o),
    .exception_syndrome_o (exception_syndrome_o)
  );

  always #12.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there and once more after
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk("read data", {32'h0, rdata_o}, {32'h0, exp});
    @(posedge clk_i);
    #1;
    chk("read data idle", {32'h0, rdata_o}, 64'h0);
  endtask

  task automatic take(input syndrome_pkg::exc_event_t ev);
    @(posedge clk_i);
    exc_take_i <= 1'b1;
    exc_i      <= ev;
    @(posedge clk_i);
    exc_take_i <= 1'b0;
    #1;
  endtask

  // One exception with a plain detail field; class, length, syndrome and upper half checked together
  task automatic run(input syndrome_pkg::src_t s, input logic low, input logic nar, input logic wide,
                     input logic sv, input logic [5:0] cls, input logic il);
    syndrome_pkg::exc_event_t ev;
    ev                = '0;
    ev.src            = s;
    ev.lower_level    = low;
    ev.from_narrow    = nar;
    ev.instr_wide     = wide;
    ev.syndrome_valid = sv;
    ev.detail         = DETAIL;
    take(ev);
    chk("class", {58'h0, exception_syndrome_o[31:26]}, {58'h0, cls});
    chk("length", {63'h0, exception_syndrome_o[25]}, {63'h0, il});
    chk("syndrome", {39'h0, exception_syndrome_o[24:0]},
        {39'h0, (cls == syndrome_pkg::EC_UNKNOWN) ? 25'h0 : DETAIL});
    chk("upper half", {32'h0, exception_syndrome_o[63:32]}, 64'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #250000;
    err_total++;
    close_out();
  end

  initial begin
    syndrome_pkg::exc_event_t ev;
    clk_i = 1'b0; rst_i = 1'b1; exc_take_i = 1'b0; exc_i = '0;
    addr_i = 4'h0; wdata_i = 32'h0; wr_i = 1'b0; rd_i = 1'b0;
    err_total = 0; total_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("rdata after reset", {32'h0, rdata_o}, 64'h0);
    reg_rd(4'hc, 32'h0000000f);
    run(syndrome_pkg::SRC_TXN_BEGIN, 1'b0, 1'b0, 1'b1, 1'b1, 6'h1b, 1'b1);
    run(syndrome_pkg::SRC_PTR_AUTH, 1'b0, 1'b0, 1'b1, 1'b1, 6'h1c, 1'b1);
    run(syndrome_pkg::SRC_MATRIX, 1'b1, 1'b0, 1'b0, 1'b1, 6'h1d, 1'b0);
    run(syndrome_pkg::SRC_GRANULE, 1'b0, 1'b0, 1'b1, 1'b1, 6'h1e, 1'b1);
    run(syndrome_pkg::SRC_IABT, 1'b1, 1'b0, 1'b0, 1'b1, 6'h20, 1'b1);
    run(syndrome_pkg::SRC_IABT, 1'b0, 1'b0, 1'b0, 1'b1, 6'h21, 1'b1);
    run(syndrome_pkg::SRC_PC_ALIGN, 1'b0, 1'b0, 1'b0, 1'b1, 6'h22, 1'b1);
    run(syndrome_pkg::SRC_DABT, 1'b1, 1'b0, 1'b0, 1'b1, 6'h24, 1'b0);
    run(syndrome_pkg::SRC_DABT, 1'b0, 1'b0, 1'b0, 1'b0, 6'h25, 1'b1);
    run(syndrome_pkg::SRC_SP_ALIGN, 1'b1, 1'b0, 1'b0, 1'b1, 6'h26, 1'b1);
    run(syndrome_pkg::SRC_FP_TRAP, 1'b0, 1'b1, 1'b0, 1'b1, 6'h28, 1'b0);
    run(syndrome_pkg::SRC_FP_TRAP, 1'b0, 1'b0, 1'b1, 1'b1, 6'h2c, 1'b1);
    run(syndrome_pkg::SRC_SYS_ERROR, 1'b1, 1'b0, 1'b0, 1'b1, 6'h2f, 1'b1);
    run(syndrome_pkg::SRC_HW_COMPACT_BREAKPOINT_INSTR, 1'b1, 1'b0, 1'b0, 1'b1, 6'h30, 1'b1);
    run(syndrome_pkg::SRC_HW_COMPACT_BREAKPOINT_INSTR, 1'b0, 1'b0, 1'b0, 1'b1, 6'h31, 1'b1);
    run(syndrome_pkg::SRC_STEP, 1'b1, 1'b0, 1'b0, 1'b1, 6'h32, 1'b1);
    run(syndrome_pkg::SRC_STEP, 1'b0, 1'b0, 1'b0, 1'b1, 6'h33, 1'b1);
    run(syndrome_pkg::SRC_WATCH, 1'b1, 1'b0, 1'b0, 1'b1, 6'h34, 1'b1);
    run(syndrome_pkg::SRC_WATCH, 1'b0, 1'b0, 1'b0, 1'b1, 6'h35, 1'b1);
    run(syndrome_pkg::SRC_BRK_INSTR, 1'b0, 1'b1, 1'b0, 1'b1, 6'h38, 1'b0);
    run(syndrome_pkg::SRC_BRK_INSTR, 1'b0, 1'b0, 1'b1, 1'b1, 6'h3c, 1'b1);
    run(syndrome_pkg::SRC_UNDEF, 1'b0, 1'b0, 1'b0, 1'b1, 6'h00, 1'b1);
    // Narrow register fifteen, predictable: subfield reads all ones in the wide numbering
    ev = '0;
    ev.src = syndrome_pkg::SRC_DABT;
    ev.from_narrow = 1'b1;
    ev.syndrome_valid = 1'b1;
    ev.instr_wide = 1'b1;
    ev.reg_present = 1'b1;
    ev.narrow_reg = 4'hf;
    ev.predictable = 1'b1;
    take(ev);
    chk("register subfield", {59'h0, exception_syndrome_o[REG_LSB +: 5]}, 64'h1f);
    ev.narrow_reg = 4'h3;
    take(ev);
    chk("register three", {59'h0, exception_syndrome_o[REG_LSB +: 5]}, 64'h03);
    ev.predictable = 1'b0;
    take(ev);
    chk("unpredictable subfield", {59'h0, exception_syndrome_o[REG_LSB +: 5]}, 64'h1f);
    // Status flags the capture, then clears on its own read
    reg_rd(4'h8, 32'h00000001);
    reg_rd(4'h8, 32'h00000000);
    // Software write of a reserved class is stored raw; upper half stays zero
    reg_wr(4'h0, 32'hb6123456);
    chk("written low", exception_syndrome_o, 64'h00000000b6123456);
    reg_wr(4'h4, 32'hffffffff);
    chk("upper write ignored", exception_syndrome_o, 64'h00000000b6123456);
    reg_rd(4'h0, 32'hb6123456);
    reg_rd(4'h4, 32'h00000000);
    reg_rd(4'h2, 32'h00000000);
    // Capture and write on one edge: capture must win with every field from the exception
    ev = '0;
    ev.src = syndrome_pkg::SRC_SYS_ERROR;
    ev.detail = DETAIL;
    @(posedge clk_i);
    exc_take_i <= 1'b1;
    exc_i      <= ev;
    wr_i       <= 1'b1;
    addr_i     <= 4'h0;
    wdata_i    <= 32'h12345678;
    @(posedge clk_i);
    exc_take_i <= 1'b0;
    wr_i       <= 1'b0;
    #1;
    chk("capture over write", exception_syndrome_o, {32'h0, 6'h2f, 1'b1, DETAIL});
    // Second reset in mid-run brings the features back
    // Features off: the gated classes fall back to unknown with length one and no syndrome
    reg_wr(4'hc, 32'h00000000);
    run(syndrome_pkg::SRC_PTR_AUTH, 1'b0, 1'b0, 1'b1, 1'b1, 6'h00, 1'b1);
    run(syndrome_pkg::SRC_GRANULE, 1'b0, 1'b0, 1'b0, 1'b1, 6'h00, 1'b1);
    run(syndrome_pkg::SRC_FP_TRAP, 1'b0, 1'b1, 1'b0, 1'b1, 6'h00, 1'b1);
    reg_rd(4'hc, 32'h00000000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_rd(4'hc, 32'h0000000f);
    run(syndrome_pkg::SRC_IABT, 1'b1, 1'b0, 1'b0, 1'b1, 6'h20, 1'b1);
    close_out();
  end
endmodule
